// [hdl/timer_cc_pkg.sv]
// constants, field layouts and types for the capture/compare/gated timer
// assumes a classic wishbone slave with 32-bit data, one aligned word per register
//
// Operation
// [R1] capture mode: selected input edge copies the 16-bit count into the capture value
// [R2] polarity bit picks rising or falling edge as the capture edge
// [R3] capture event raises interrupt, sets capture cause flag, counter keeps running
// [R4] capture mode: count reaching reload raises interrupt, clears cause flag, keeps counting
// [R5] interrupt source select: both events by default, or capture only, or reload only
// [R6] software clears capture value to 0000H before enabling the timer
// [R7] software disables the timer before changing settings, enables it last
// [R8] capture-restart: capture stores count, interrupts, sets flag, reloads count with 0001H
// [R9] capture-restart: reaching reload interrupts, clears flag, restarts count at 0001H
// [R10] capture-restart needs the mode extension bit plus the main mode field
// [R11] compare mode: count equal to compare value interrupts, counting continues, no reload
// [R12] compare mode: output pin inverts at each match when output enabled
// [R13] compare mode: counter wraps from FFFFH to 0000H
// [R14] compare mode: output starts at the level programmed before enabling
// [R15] gated mode: counter advances only while input is at the active level
// [R16] gated mode: interrupt on input leaving active level and on reload
// [R17] gated mode: reaching reload interrupts, count restarts at 0001H if still active
// [R18] gated mode: software start count only affects the first pass
// [R19] gated mode: output pin inverts at each reload when output enabled
// [R20] gated mode: source select picks deassertion only, reload only, or both
// [R21] software tells deassertion from reload by reading input level against polarity
// [R22] counter clocked by prescaled system clock, never by the external input
// [R23] reload high byte buffered, written together with the low byte
// [R24] while enabled, count high read latches low byte for the next low read
// [R25] external input synchronised before edge or level detection
// [R26] gated mode: count held while input inactive, resumes from that value

package timer_cc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CTRL2 = 6'h04;
  localparam logic [5:0] OFS_CNT_HI = 6'h08;
  localparam logic [5:0] OFS_CNT_LO = 6'h0c;
  localparam logic [5:0] OFS_RLD_HI = 6'h10;
  localparam logic [5:0] OFS_RLD_LO = 6'h14;
  localparam logic [5:0] OFS_CAP_HI = 6'h18;
  localparam logic [5:0] OFS_CAP_LO = 6'h1c;
  localparam logic [5:0] OFS_STATUS = 6'h20;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] CTRL2_RESET = 3'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0001;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [6:0] PRESCALE_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // modes and field layouts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_GATED,
    MODE_SPARE
  } mode_t;

  typedef enum logic [1:0] {
    SRC_BOTH,
    SRC_EVENT_ONLY,
    SRC_RELOAD_ONLY,
    SRC_BOTH_ALT
  } src_sel_t;

  // main control: bit0 enable, [2:1] mode, [5:3] prescale log2, [6] polarity, [7] output enable
  typedef struct packed {
    logic out_enable;
    logic input_polarity_select;
    logic [2:0] prescale;
    mode_t mode;
    logic enable;
  } ctrl_t;

  // second control: bit0 mode extension, [2:1] interrupt source select
  typedef struct packed {
    src_sel_t interrupt_source_select;
    logic mode_extension_bit;
  } ctrl2_t;

endpackage : timer_cc_pkg

// [hdl/timer_capture_compare_gated.sv]
// 16-bit timer with capture, capture-restart, compare and gated modes
// assumes a classic wishbone master and a timer input synchronous to nothing
`timescale 1ns/1ps

module timer_capture_compare_gated
  import timer_cc_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer pins
  input wire logic timer_in_i,
  output logic timer_out_o,
  output logic timer_out_en_o,
  output logic timer_irq_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  ctrl_t ctrl_r;
  ctrl2_t ctrl2_r;
  logic [15:0] count_r, count_nxt;
  logic [15:0] reload_r;
  logic [7:0] reload_hi_buf_r;
  logic [15:0] capture_r;
  logic [7:0] low_hold_r;
  logic cause_flag_r, cause_flag_nxt;
  logic tout_r, tout_nxt;
  logic irq_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [6:0] pre_cnt_r;
  logic in_q1_r, in_q2_r, in_q3_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i;
  wire rd_go = req && !ack_r && !wb_we_i;
  wire wr_go = req && ack_r && wb_we_i && wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire wr_ctrl = wr_go && (wb_adr_i == OFS_CTRL);
  wire wr_ctrl2 = wr_go && (wb_adr_i == OFS_CTRL2);
  wire wr_cnt_hi = wr_go && (wb_adr_i == OFS_CNT_HI);
  wire wr_cnt_lo = wr_go && (wb_adr_i == OFS_CNT_LO);
  wire wr_rld_hi = wr_go && (wb_adr_i == OFS_RLD_HI);
  wire wr_rld_lo = wr_go && (wb_adr_i == OFS_RLD_LO);
  wire wr_cap_hi = wr_go && (wb_adr_i == OFS_CAP_HI);
  wire wr_cap_lo = wr_go && (wb_adr_i == OFS_CAP_LO);
  wire rd_cnt_hi = rd_go && (wb_adr_i == OFS_CNT_HI);
  wire cnt_wr = wr_cnt_hi || wr_cnt_lo;

  // ----------------------------------------------------------------
  // input synchroniser and edge detection
  // ----------------------------------------------------------------
  wire in_rise = in_q2_r && !in_q3_r;
  wire in_fall = !in_q2_r && in_q3_r;
  wire pol = ctrl_r.input_polarity_select;
  wire in_active = (in_q2_r == pol); // [R15]
  wire sel_edge = pol ? in_rise : in_fall; // [R2] [R25]
  wire leave_edge = pol ? in_fall : in_rise; // [R16]

  // ----------------------------------------------------------------
  // mode decode and prescaler
  // ----------------------------------------------------------------
  wire en = ctrl_r.enable;
  wire m_cap = en && (ctrl_r.mode == MODE_CAPTURE) && !ctrl2_r.mode_extension_bit;
  wire m_restart = en && (ctrl_r.mode == MODE_CAPTURE) && ctrl2_r.mode_extension_bit; // [R10]
  wire m_cmp = en && (ctrl_r.mode == MODE_COMPARE);
  wire m_gate = en && (ctrl_r.mode == MODE_GATED);
  wire [6:0] pre_max = 7'((8'h01 << ctrl_r.prescale) - 8'h01);
  // gated mode clears the prescaler too, so a pass resumes with no partial tick
  wire pre_run = en && (!m_gate || in_active);
  wire tick = pre_run && (pre_cnt_r == pre_max); // [R22]
  wire at_reload = (count_r == reload_r);

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  wire cap_ev = (m_cap || m_restart) && sel_edge; // [R1]
  wire deassert_ev = m_gate && leave_edge; // [R16]
  wire reload_ev = tick && at_reload && (m_cap || m_restart || m_cmp || m_gate);
  wire src_event = cap_ev || deassert_ev;
  wire allow_event = (ctrl2_r.interrupt_source_select != SRC_RELOAD_ONLY);
  wire allow_reload = (ctrl2_r.interrupt_source_select != SRC_EVENT_ONLY);
  wire irq_set = (src_event && allow_event) || (reload_ev && allow_reload); // [R5] [R20]

  // ----------------------------------------------------------------
  // counter, flag and output next state
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (m_restart && cap_ev) begin
      count_nxt = COUNT_RESTART; // [R8]
    end else if (tick) begin
      if (at_reload && (m_restart || m_gate)) begin
        count_nxt = COUNT_RESTART; // [R9] [R17] [R18]
      end else begin
        count_nxt = count_r + 16'h0001; // [R4] [R11] [R13]
      end
    end
    if (wr_cnt_hi) begin
      count_nxt[15:8] = wbyte;
    end
    if (wr_cnt_lo) begin
      count_nxt[7:0] = wbyte;
    end
  end

  always_comb begin
    cause_flag_nxt = cause_flag_r;
    if (reload_ev && (m_cap || m_restart)) begin
      cause_flag_nxt = 1'b0; // [R4] [R9]
    end
    // a capture in the same cycle as a reload wins
    if (cap_ev) begin
      cause_flag_nxt = 1'b1; // [R3] [R8]
    end
  end

  always_comb begin
    tout_nxt = tout_r;
    if (!en) begin
      tout_nxt = pol; // [R14]
    end else if (reload_ev && (m_cmp || m_gate)) begin
      tout_nxt = !tout_r; // [R12] [R19]
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      in_q1_r <= 1'b0;
      in_q2_r <= 1'b0;
      in_q3_r <= 1'b0;
      pre_cnt_r <= PRESCALE_ZERO;
      count_r <= COUNT_RESET;
      cause_flag_r <= 1'b0;
      tout_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce_i) begin
      in_q1_r <= timer_in_i;
      in_q2_r <= in_q1_r; // [R25]
      in_q3_r <= in_q2_r;
      pre_cnt_r <= (!pre_run || tick) ? PRESCALE_ZERO : pre_cnt_r + 7'h01;
      count_r <= count_nxt; // [R26]
      cause_flag_r <= cause_flag_nxt;
      tout_r <= tout_nxt;
      irq_r <= irq_set;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      capture_r <= CAPTURE_RESET;
    end else if (ce_i) begin
      if (cap_ev) begin
        capture_r <= count_r; // [R1]
      end else if (wr_cap_hi) begin
        capture_r[15:8] <= wbyte;
      end else if (wr_cap_lo) begin
        capture_r[7:0] <= wbyte;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ctrl_r <= ctrl_t'(CTRL_RESET);
      ctrl2_r <= ctrl2_t'(CTRL2_RESET);
      reload_r <= RELOAD_RESET;
      reload_hi_buf_r <= RELOAD_RESET[15:8];
      low_hold_r <= COUNT_RESET[7:0];
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_t'(wbyte);
      end
      if (wr_ctrl2) begin
        ctrl2_r <= ctrl2_t'(wbyte[2:0]);
      end
      if (wr_rld_hi) begin
        reload_hi_buf_r <= wbyte; // [R23]
      end
      if (wr_rld_lo) begin
        reload_r <= {reload_hi_buf_r, wbyte}; // [R23]
      end
      if (rd_cnt_hi && en) begin
        low_hold_r <= count_r[7:0]; // [R24]
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] cnt_lo_view = en ? low_hold_r : count_r[7:0]; // [R24]
  wire [31:0] ctrl2_view = {28'h0000000, cause_flag_r, ctrl2_r};
  wire [31:0] status_view = {30'h0, tout_r, in_q2_r}; // [R21]
  wire [31:0] rd_mux =
    (wb_adr_i == OFS_CTRL) ? {24'h000000, ctrl_r} :
    (wb_adr_i == OFS_CTRL2) ? ctrl2_view :
    (wb_adr_i == OFS_CNT_HI) ? {24'h000000, count_r[15:8]} :
    (wb_adr_i == OFS_CNT_LO) ? {24'h000000, cnt_lo_view} :
    (wb_adr_i == OFS_RLD_HI) ? {24'h000000, reload_r[15:8]} :
    (wb_adr_i == OFS_RLD_LO) ? {24'h000000, reload_r[7:0]} :
    (wb_adr_i == OFS_CAP_HI) ? {24'h000000, capture_r[15:8]} :
    (wb_adr_i == OFS_CAP_LO) ? {24'h000000, capture_r[7:0]} :
    (wb_adr_i == OFS_STATUS) ? status_view : 32'h00000000;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      ack_r <= req && !ack_r;
      if (rd_go) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign timer_out_o = tout_r;
  assign timer_out_en_o = ctrl_r.out_enable;
  assign timer_irq_o = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_hi_read_enabled;
    ce_i && rd_cnt_hi && en;
  endsequence

  sequence s_lo_read_next;
    ce_i && rd_go && (wb_adr_i == OFS_CNT_LO) && en;
  endsequence

  property p_capture_store;
    (ce_i && cap_ev) |=> (capture_r == $past(count_r));
  endproperty
  a_capture_store: assert property (p_capture_store) else $error("capture value not stored"); // [R1]

  property p_edge_polarity;
    (ce_i && (m_cap || m_restart) && pol && in_q2_r && !in_q3_r) |-> cap_ev;
  endproperty
  a_edge_polarity: assert property (p_edge_polarity) else $error("rising edge missed"); // [R2]

  property p_capture_flag;
    (ce_i && m_cap && cap_ev && !cnt_wr && !tick) |=> (cause_flag_r && count_r == $past(count_r));
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture flag or count wrong"); // [R3]

  property p_reload_clear;
    (ce_i && m_cap && reload_ev && !cap_ev) |=> !cause_flag_r;
  endproperty
  a_reload_clear: assert property (p_reload_clear) else $error("cause flag not cleared"); // [R4]

  property p_src_reload_only;
    (ce_i && ctrl2_r.interrupt_source_select == SRC_RELOAD_ONLY && src_event && !reload_ev) |=> !timer_irq_o;
  endproperty
  a_src_reload_only: assert property (p_src_reload_only) else $error("event irq not masked"); // [R5] [R20]

  property p_restart_one;
    (ce_i && m_restart && cap_ev && !cnt_wr) |=> (count_r == COUNT_RESTART) && timer_irq_o == allow_event;
  endproperty
  a_restart_one: assert property (p_restart_one) else $error("restart count wrong"); // [R8]

  property p_compare_continue;
    (ce_i && m_cmp && reload_ev && !cnt_wr) |=> (count_r == 16'($past(count_r) + 16'h0001));
  endproperty
  a_compare_continue: assert property (p_compare_continue) else $error("compare reloaded count"); // [R11] [R13]

  property p_toggle;
    (ce_i && (m_cmp || m_gate) && reload_ev) |=> (timer_out_o != $past(timer_out_o));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle"); // [R12] [R19]

  property p_gated_hold;
    (ce_i && m_gate && !in_active && !cnt_wr) |=> $stable(count_r);
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("gated count moved"); // [R26] [R15]

  property p_reload_atomic;
    (ce_i && wr_rld_hi) |=> $stable(reload_r);
  endproperty
  a_reload_atomic: assert property (p_reload_atomic) else $error("reload high not buffered"); // [R23]

  property p_low_latch;
    s_hi_read_enabled ##1 (!(ce_i && rd_cnt_hi))[*1] |-> (low_hold_r == $past(count_r[7:0]));
  endproperty
  a_low_latch: assert property (p_low_latch) else $error("low byte not latched"); // [R24]

  property p_low_returned;
    s_hi_read_enabled ##[1:20] s_lo_read_next |=> (wb_dat_o[7:0] == low_hold_r);
  endproperty
  a_low_returned: assert property (p_low_returned) else $error("low read not from holding"); // [R24]

  property p_restart_reload;
    (ce_i && m_restart && reload_ev && !cap_ev && !cnt_wr) |=> (count_r == COUNT_RESTART) && !cause_flag_r;
  endproperty
  a_restart_reload: assert property (p_restart_reload) else $error("restart reload wrong"); // [R9]

  property p_gated_reload;
    (ce_i && m_gate && reload_ev && !cnt_wr) |=> (count_r == COUNT_RESTART);
  endproperty
  a_gated_reload: assert property (p_gated_reload) else $error("gated pass did not restart"); // [R17] [R18]

  property p_deassert_irq;
    (ce_i && deassert_ev && allow_event) |=> timer_irq_o;
  endproperty
  a_deassert_irq: assert property (p_deassert_irq) else $error("deassertion irq missing"); // [R16] [R20]

  property p_reload_irq;
    (ce_i && reload_ev && allow_reload) |=> timer_irq_o;
  endproperty
  a_reload_irq: assert property (p_reload_irq) else $error("reload irq missing"); // [R5]

  property p_idle_level;
    (ce_i && !en) |=> (timer_out_o == $past(pol));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle output level wrong"); // [R14]

  property p_no_tick_hold;
    (ce_i && (m_cap || m_cmp) && !tick && !cap_ev && !cnt_wr) |=> $stable(count_r);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved without tick"); // [R22]

  property p_single_edge;
    (ce_i && sel_edge && !wr_ctrl) |=> !sel_edge;
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("one transition seen twice"); // [R25]

endmodule : timer_capture_compare_gated

// [sim/timer_pin_model.sv]
// ----------------------------------------------------------------
// far-side model: drives the timer input pin, watches the output pin
// ----------------------------------------------------------------
// assumes the bench asks for input levels on rising clock edges
`timescale 1ns/1ps

module timer_pin_model (
  // clock
  input wire logic clock_i,
  // level asked for by the bench
  input wire logic level_i,
  // timer pins
  input wire logic timer_out_i,
  output logic timer_in_o,
  output int toggles_o
);
  logic last_r;

  // pin is registered on clock_i, the same clock that drives the sampling stage
  always @(posedge clock_i) begin
    timer_in_o <= level_i;
    last_r <= timer_out_i;
    if (timer_out_i !== last_r) begin
      toggles_o <= toggles_o + 1;
    end
  end
endmodule : timer_pin_model

// [sim/timer_capture_compare_gated_test.sv]
// ----------------------------------------------------------------
// self-checking bench for the capture/compare/gated timer
// ----------------------------------------------------------------
// assumes timer_pin_model on the pins and a slave that acks every request
`timescale 1ns/1ps

module timer_capture_compare_gated_test
  import timer_cc_pkg::*;
();
  logic clock, reset_n, cyc, stb, we, lvl, ack, t_out, t_oe, irq, t_in, ce;
  logic [5:0] adr;
  logic [31:0] wdat, rdat;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [7:0] v, rv;
  logic [15:0] st;
  ctrl_t cr;
  int toggles, irq_n, b, t0, bad_count, checked;
  localparam logic [5:0] RA [8] = '{OFS_CTRL, OFS_CTRL2, OFS_CNT_HI, OFS_CNT_LO, OFS_RLD_HI, OFS_RLD_LO,
    OFS_CAP_HI, OFS_STATUS};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00};

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  timer_capture_compare_gated dut_u (.clock_i(clock), .reset_n_i(reset_n), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_in_i(t_in), .timer_out_o(t_out), .timer_out_en_o(t_oe), .timer_irq_o(irq));
  timer_pin_model pin_u (.clock_i(clock), .level_i(lvl), .timer_out_i(t_out), .timer_in_o(t_in),
    .toggles_o(toggles));

  // ----------------------------------------------------------------
  // watchers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() != 0) begin
      e = exp_q.pop_front();
      if (e[32]) chk(rdat, {24'h0, e[7:0]});
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // wishbone classic master
  // ----------------------------------------------------------------
  // ack is sampled at the rising edge; data taken and request dropped at that same edge
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    rv = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wait_ack

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= a;
    wdat <= {24'h0, d};
    wait_ack();
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] x, input logic c);
    exp_q.push_back({c, 24'h0, x});
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    wait_ack();
    v = rv;
  endtask : rd

  task automatic cfg(input mode_t m, input logic [2:0] p, input logic pol, oe, ext, input src_sel_t s,
    input logic [15:0] s0, r);
    ctrl2_t c2;
    c2 = '{s, ext};
    cr = '{oe, pol, p, m, 1'b0};
    wr(OFS_CTRL, cr);
    wr(OFS_CTRL2, {5'h0, c2});
    wr(OFS_CNT_HI, s0[15:8]);
    wr(OFS_CNT_LO, s0[7:0]);
    wr(OFS_RLD_HI, r[15:8]);
    wr(OFS_RLD_LO, r[7:0]);
    wr(OFS_CAP_HI, 8'h00);
    wr(OFS_CAP_LO, 8'h00);
  endtask : cfg

  task automatic en();
    cr.enable = 1'b1;
    wr(OFS_CTRL, cr);
    b = irq_n;
  endtask : en

  task automatic pin(input logic l);
    @(posedge clock);
    lvl <= l;
  endtask : pin

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    wdat = 32'h0;
    lvl = 1'b0;
    ce = 1'b1;
    irq_n = 0;
    bad_count = 0;
    checked = 0;
    void'($urandom(68131));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    foreach (RA[i]) rd(RA[i], RV[i], 1'b1);
    wr(6'h3c, 8'ha5);
    rd(6'h3c, 8'h00, 1'b1);
    st = 16'($urandom());
    wr(OFS_RLD_HI, st[15:8]);
    wr(OFS_RLD_LO, st[7:0]);
    rd(OFS_RLD_HI, st[15:8], 1'b1);
    rd(OFS_RLD_LO, st[7:0], 1'b1);
    $display("test registers finished");
    // slow prescale keeps the count still around the edge
    st = {8'($urandom_range(200)), 8'h10};
    cfg(MODE_CAPTURE, 3'h7, 1'b1, 1'b0, 1'b0, SRC_BOTH, st, 16'hffff);
    en();
    wt(8);
    pin(1'b1);
    wt(10);
    chk(irq_n - b, 1);
    pin(1'b0);
    wt(10);
    chk(irq_n - b, 1);
    rd(OFS_CAP_HI, st[15:8], 1'b1);
    rd(OFS_CAP_LO, st[7:0], 1'b1);
    rd(OFS_CTRL2, 8'h08, 1'b1);
    cfg(MODE_CAPTURE, 3'h7, 1'b0, 1'b0, 1'b0, SRC_BOTH, st, 16'hffff);
    en();
    pin(1'b1);
    wt(10);
    chk(irq_n - b, 0);
    pin(1'b0);
    wt(10);
    chk(irq_n - b, 1);
    $display("test capture edge finished");
    cfg(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, 1'b0, SRC_BOTH, 16'h0001, 16'h0040);
    en();
    pin(1'b1);
    wt(80);
    chk(irq_n - b, 2);
    rd(OFS_CTRL2, 8'h00, 1'b1);
    pin(1'b0);
    cfg(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, 1'b0, SRC_EVENT_ONLY, 16'h0001, 16'h0040);
    en();
    wt(80);
    chk(irq_n - b, 0);
    pin(1'b1);
    wt(10);
    chk(irq_n - b, 1);
    pin(1'b0);
    cfg(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, 1'b0, SRC_RELOAD_ONLY, 16'h0001, 16'h0040);
    en();
    pin(1'b1);
    wt(80);
    chk(irq_n - b, 1);
    pin(1'b0);
    $display("test capture reload finished");
    cfg(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, 1'b1, SRC_BOTH, 16'h0001, 16'h0010);
    en();
    wt(160);
    chk(32'((irq_n - b) inside {[9:11]}), 1);
    cfg(MODE_CAPTURE, 3'h7, 1'b1, 1'b0, 1'b1, SRC_BOTH, 16'h1234, 16'hffff);
    en();
    pin(1'b1);
    wt(10);
    rd(OFS_CNT_HI, 8'h00, 1'b1);
    rd(OFS_CNT_LO, 8'h01, 1'b1);
    rd(OFS_CAP_HI, 8'h12, 1'b1);
    rd(OFS_CAP_LO, 8'h34, 1'b1);
    rd(OFS_CTRL2, 8'h09, 1'b1);
    pin(1'b0);
    $display("test capture restart finished");
    cfg(MODE_COMPARE, 3'h0, 1'b1, 1'b1, 1'b0, SRC_BOTH, 16'hfff0, 16'h0008);
    wt(2);
    chk(32'({t_oe, t_out}), 3);
    en();
    wt(40);
    chk(irq_n - b, 1);
    chk(32'(t_out), 0);
    cr.enable = 1'b0;
    wr(OFS_CTRL, cr);
    rd(OFS_CNT_HI, 8'h00, 1'b1);
    rd(OFS_CNT_LO, 8'h00, 1'b0);
    chk(32'(v inside {[8'h14:8'h30]}), 1);
    $display("test compare finished");
    cfg(MODE_GATED, 3'h0, 1'b1, 1'b1, 1'b0, SRC_BOTH, 16'h0005, 16'h0100);
    en();
    wt(20);
    rd(OFS_CNT_HI, 8'h00, 1'b1);
    rd(OFS_CNT_LO, 8'h05, 1'b1);
    pin(1'b1);
    wt(20);
    pin(1'b0);
    wt(10);
    chk(irq_n - b, 1);
    rd(OFS_CNT_HI, 8'h00, 1'b1);
    rd(OFS_CNT_LO, 8'h00, 1'b0);
    chk(32'(v inside {[8'h17:8'h1b]}), 1);
    wt(10);
    rd(OFS_CNT_LO, v, 1'b1);
    rd(OFS_STATUS, 8'h00, 1'b0);
    chk(32'(v[0] !== cr.input_polarity_select), 1);
    cfg(MODE_GATED, 3'h0, 1'b1, 1'b1, 1'b0, SRC_RELOAD_ONLY, 16'h0005, 16'h0008);
    en();
    t0 = toggles;
    pin(1'b1);
    wt(45);
    pin(1'b0);
    wt(10);
    chk(32'((irq_n - b) inside {[5:6]}), 1);
    chk(toggles - t0, irq_n - b);
    $display("test gated finished");
    // clock enable low for 30 edges: count must freeze, only 4 ticks land
    cfg(MODE_COMPARE, 3'h0, 1'b1, 1'b0, 1'b0, SRC_BOTH, 16'h0100, 16'hffff);
    en();
    @(posedge clock);
    ce <= 1'b0;
    wt(30);
    ce <= 1'b1;
    cr.enable = 1'b0;
    wr(OFS_CTRL, cr);
    rd(OFS_CNT_HI, 8'h01, 1'b1);
    rd(OFS_CNT_LO, 8'h00, 1'b0);
    chk(32'(v inside {[8'h03:8'h06]}), 1);
    $display("test clock enable finished");
    report_and_stop();
  end
endmodule : timer_capture_compare_gated_test
